// >>> hdl/esvs_defines.svh
// Offsets, field positions and reset values of the error sync block
`ifndef ESVS_DEFINES_SVH
`define ESVS_DEFINES_SVH

// ---------------------------------------------------------------
// Register offsets (byte addresses)
// ---------------------------------------------------------------
`define ESVS_ADDR_W 5
`define ESVS_OFF_HCTL 5'h00
`define ESVS_OFF_VSYN 5'h04
`define ESVS_OFF_VREC 5'h08
`define ESVS_OFF_SCTL 5'h0c
`define ESVS_OFF_STAT 5'h10

// ---------------------------------------------------------------
// Field positions
// ---------------------------------------------------------------
`define ESVS_HCTL_EN 0
`define ESVS_HCTL_ROUTE 1
`define ESVS_HCTL_TGE 2
`define ESVS_HCTL_INJ 3
`define ESVS_VREC_PEND 31
`define ESVS_SCTL_ISE_HI 3
`define ESVS_SCTL_ISE_LO 1
`define ESVS_SCTL_NMEA 4
`define ESVS_STAT_ILL 4
`define ESVS_STAT_VPEND 5

// ---------------------------------------------------------------
// Levels and reset values
// ---------------------------------------------------------------
`define ESVS_EL0 2'h0
`define ESVS_EL3 2'h3
`define ESVS_ZERO32 32'h0000_0000
`define ESVS_ISE_RST 4'h0

`endif

// >>> hdl/esvs_pkg.sv
// Types shared by the error sync block and its users
package esvs_pkg;

   // ------------------------------------------------------------
   // Enumerations
   // ------------------------------------------------------------
   // Preferred return address selection for a taken error
   typedef enum logic [1:0] {
      ESVS_RET_INSTR,
      ESVS_RET_VECTOR,
      ESVS_RET_ERET,
      ESVS_RET_ORIG
   } esvs_ret_t;

   // Origin of a synchronization event
   typedef enum logic [1:0] {
      ESVS_SRC_BARRIER,
      ESVS_SRC_ENTRY,
      ESVS_SRC_RETURN,
      ESVS_SRC_DEBUG
   } esvs_src_t;

   // ------------------------------------------------------------
   // Carriers
   // ------------------------------------------------------------
   // Instruction and exception strobes from the pipeline
   typedef struct packed {
      logic error_sync_barrier_instr;
      logic entry;
      logic eret;
      logic dcps;
      logic debug_restore_state;
      logic [1:0] el;
      logic raises_exc;
      logic illegal;
      logic next_instr;
   } esvs_evt_t;

   // Processor state seen by the block
   typedef struct packed {
      logic [1:0] cur_el;
      logic [3:0] a64;
      logic debug;
      logic virt_masked;
      logic [3:0] phys_masked;
      logic phys_pend;
      logic idef_pend;
      logic idef_sync;
   } esvs_core_t;

   // Error taken by the block
   typedef struct packed {
      logic take_phys;
      logic take_virt;
      logic iesb_flag;
      esvs_ret_t ret_sel;
   } esvs_take_t;

endpackage : esvs_pkg

// >>> hdl/esvs_unit.sv
// Error synchronization and virtual system error handling unit
//
// Contract
// - Barrier at level 0/1 syncs injected virtual error.
// - Unmasked synced virtual error taken before barrier completes.
// - Masked: clear inject, copy syndrome, set pending.
// - Read-as-zero syndrome: optional sync, zero recorded.
// - Unsynced virtual error ignored, stays pending.
// - Own-source error needs route 1, trap 0; masked records it.
// - Own-source error not sync-capable stays pending.
// - Virtual handling runs beside physical sync.
// - Implicit events leave deferred records alone.
// - Double fault and nonmaskable enable force level 3 enable.
// - Entry to enabled 64-bit level 1..3 makes event.
// - Debug level switch to enabled level makes event.
// - Error taken at entry event: flag set, vector return.
// - Masked errors stay pending after entry event.
// - Optional in-place take with flag zero.
// - With double fault, entry to level 3 keeps the event.
// - Fault-free return at enabled level makes event.
// - Illegal return sets flag; next instruction traps.
// - Fault-free debug restore at enabled level makes event.
// - Implicit sync exists only with the feature.
//
// The address-and-strobe port and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
`include "esvs_defines.svh"

module esvs_unit #(
   parameter int SYN_W = 25,
   parameter bit IMPLICIT_SYNC_FEATURE = 1'b1,
   parameter bit DOUBLE_FAULT_FEATURE = 1'b1,
   parameter bit SYN_WRITABLE = 1'b1,
   parameter bit RAZ_SYNC = 1'b1,
   parameter bit TAKE_IN_PLACE = 1'b0,
   parameter bit ERET_FLAG = 1'b0,
   parameter logic [SYN_W-1:0] IDEF_SYN = 25'h100_0000
) (
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic ce,
   input wire logic [`ESVS_ADDR_W-1:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [31:0] reg_rdata,
   input wire esvs_pkg::esvs_evt_t evt,
   input wire esvs_pkg::esvs_core_t core,
   output esvs_pkg::esvs_take_t take,
   output logic sync_event,
   output esvs_pkg::esvs_src_t sync_src,
   output logic phys_sync,
   output logic idef_clear,
   output logic barrier_done,
   output logic illegal_state_flag,
   output logic illegal_state_exc,
   output logic virt_error_inject
);

   // ------------------------------------------------------------
   // Storage
   // ------------------------------------------------------------
   logic el2_en_q, hyp_async_abort_route_q, hyp_trap_general_q, inject_q;
   logic [SYN_W-1:0] virt_syndrome_reg_q, rec_syn_q;
   logic rec_pend_q, nonmaskable_abort_enable_q, illegal_q;
   logic [3:0] implicit_sync_enable_q;

   // ------------------------------------------------------------
   // Decode and qualifiers
   // ------------------------------------------------------------
   logic wr_hctl, wr_vsyn, wr_vrec, wr_sctl, virt_route, barrier, inj_sync;
   logic idef_go, phys_take_cur, entry_sync, entry_unmasked, in_place_ok;
   logic ret_sync, dcps_sync, debug_restore_state_sync;
   logic [3:0] ise_eff;

   assign wr_hctl = ce && reg_wr && (reg_addr == `ESVS_OFF_HCTL);
   assign wr_vsyn = ce && reg_wr && (reg_addr == `ESVS_OFF_VSYN);
   assign wr_vrec = ce && reg_wr && (reg_addr == `ESVS_OFF_VREC);
   assign wr_sctl = ce && reg_wr && (reg_addr == `ESVS_OFF_SCTL);

   // Effective implicit-sync enables; level 0 never has one
   // forced level 3 enable
   assign ise_eff = {implicit_sync_enable_q[3]
                        | (DOUBLE_FAULT_FEATURE
                           && nonmaskable_abort_enable_q),
                     implicit_sync_enable_q[2:1], 1'b0};

   // Level qualifies for implicit sync: feature, 64-bit, enabled
   function automatic logic iesb_on(input logic [1:0] el,
                                    input logic [3:0] a64,
                                    input logic [3:0] ise);
      iesb_on = IMPLICIT_SYNC_FEATURE && (el != `ESVS_EL0)
                && a64[el] && ise[el];
   endfunction : iesb_on

   // Hypervisor routing for virtual errors
   // route set, trap clear
   assign virt_route = el2_en_q && hyp_async_abort_route_q
                       && !hyp_trap_general_q;

   // Barrier executed at level 0 or 1
   assign barrier = ce && evt.error_sync_barrier_instr && (core.cur_el <= 2'h1);

   // read-as-zero case syncs only when chosen
   assign inj_sync = barrier && virt_route && inject_q
                     && (SYN_WRITABLE || RAZ_SYNC);

   // Own-source error synchronized only when it is sync-capable
   // others are left alone
   assign idef_go = barrier && virt_route && core.idef_pend
                    && core.idef_sync && !inj_sync;

   assign phys_take_cur = core.phys_pend
                          && !core.phys_masked[core.cur_el];

   // sync on entry to qualifying level
   assign entry_sync = ce && evt.entry
                       && iesb_on(evt.el, core.a64, ise_eff);
   assign entry_unmasked = core.phys_pend
                           && !core.phys_masked[evt.el];

   // with double fault, never bypass the event on entry to level 3
   assign in_place_ok = TAKE_IN_PLACE
                        && !(DOUBLE_FAULT_FEATURE
                             && (evt.el == `ESVS_EL3));

   // return without exception at qualifying level
   assign ret_sync = ce && evt.eret && !evt.raises_exc
                     && iesb_on(core.cur_el, core.a64, ise_eff);

   // debug level switch in debug state
   assign dcps_sync = ce && evt.dcps && core.debug
                      && iesb_on(evt.el, core.a64, ise_eff);

   // debug restore without exception in debug state
   assign debug_restore_state_sync = ce && evt.debug_restore_state && core.debug && !evt.raises_exc
                      && iesb_on(core.cur_el, core.a64, ise_eff);

   // ------------------------------------------------------------
   // Hypervisor control register
   // ------------------------------------------------------------
   // Routing and level enable bits
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         el2_en_q <= 1'b0;
         hyp_async_abort_route_q <= 1'b0;
         hyp_trap_general_q <= 1'b0;
      end else if (wr_hctl) begin
         el2_en_q <= reg_wdata[`ESVS_HCTL_EN];
         hyp_async_abort_route_q <= reg_wdata[`ESVS_HCTL_ROUTE];
         hyp_trap_general_q <= reg_wdata[`ESVS_HCTL_TGE];
      end
   end

   // Injection bit; a software write beats the barrier's clear
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         inject_q <= 1'b0;
      end else if (wr_hctl) begin
         inject_q <= reg_wdata[`ESVS_HCTL_INJ];
      end else if (inj_sync && core.virt_masked) begin
         inject_q <= 1'b0;
      end
   end

   // ------------------------------------------------------------
   // Virtual syndrome register
   // ------------------------------------------------------------
   // Holds zero and ignores writes when built read-as-zero
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         virt_syndrome_reg_q <= '0;
      end else if (wr_vsyn && SYN_WRITABLE) begin
         virt_syndrome_reg_q <= reg_wdata[SYN_W-1:0];
      end
   end

   // ------------------------------------------------------------
   // Virtual deferred record
   // ------------------------------------------------------------
   // Barrier recording wins over a software write in the same cycle
   // a software write lands only when the barrier records nothing
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         rec_pend_q <= 1'b0;
         rec_syn_q <= '0;
      end else if (inj_sync && core.virt_masked) begin
         rec_pend_q <= 1'b1;
         rec_syn_q <= SYN_WRITABLE ? virt_syndrome_reg_q : '0;
      end else if (idef_go && core.virt_masked) begin
         rec_pend_q <= 1'b1;
         rec_syn_q <= IDEF_SYN;
      end else if (wr_vrec) begin
         rec_pend_q <= reg_wdata[`ESVS_VREC_PEND];
         rec_syn_q <= reg_wdata[SYN_W-1:0];
      end
   end

   // ------------------------------------------------------------
   // System control: implicit sync enables
   // ------------------------------------------------------------
   // Per-level enables for levels 1 to 3 and nonmaskable enable
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         implicit_sync_enable_q <= `ESVS_ISE_RST;
         nonmaskable_abort_enable_q <= 1'b0;
      end else if (wr_sctl) begin
         implicit_sync_enable_q <=
            {reg_wdata[`ESVS_SCTL_ISE_HI:`ESVS_SCTL_ISE_LO], 1'b0};
         nonmaskable_abort_enable_q <= reg_wdata[`ESVS_SCTL_NMEA];
      end
   end

   // ------------------------------------------------------------
   // Taken errors
   // ------------------------------------------------------------
   // One decision per cycle; entry, return, debug, then barrier
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         take <= '0;
      end else if (ce) begin
         take <= '0;
         if (entry_sync && entry_unmasked && in_place_ok) begin
            take.take_phys <= 1'b1;
            take.iesb_flag <= 1'b0;
            take.ret_sel <= esvs_pkg::ESVS_RET_ORIG;
         end else if (entry_sync && entry_unmasked) begin
            take.take_phys <= 1'b1;
            take.iesb_flag <= 1'b1;
            take.ret_sel <= esvs_pkg::ESVS_RET_VECTOR;
         end else if (ret_sync && phys_take_cur) begin
            take.take_phys <= 1'b1;
            take.iesb_flag <= ERET_FLAG;
            take.ret_sel <= esvs_pkg::ESVS_RET_ERET;
         end else if ((dcps_sync && entry_unmasked)
                      || (debug_restore_state_sync && phys_take_cur)) begin
            take.take_phys <= 1'b1;
            take.ret_sel <= esvs_pkg::ESVS_RET_INSTR;
         end else if (barrier && phys_take_cur) begin
            take.take_phys <= 1'b1;
            take.ret_sel <= esvs_pkg::ESVS_RET_INSTR;
         end else if ((inj_sync || idef_go) && !core.virt_masked) begin
            take.take_virt <= 1'b1;
            take.ret_sel <= esvs_pkg::ESVS_RET_INSTR;
         end
         // masked errors raise nothing and stay pending
      end
   end

   // ------------------------------------------------------------
   // Synchronization event reporting
   // ------------------------------------------------------------
   // Pulse with its origin; an in-place take skips the entry event
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         sync_event <= 1'b0;
         sync_src <= esvs_pkg::ESVS_SRC_BARRIER;
      end else if (ce) begin
         sync_event <= barrier
                       || (entry_sync
                           && !(entry_unmasked && in_place_ok))
                       || ret_sync || dcps_sync || debug_restore_state_sync;
         if (evt.entry) begin
            sync_src <= esvs_pkg::ESVS_SRC_ENTRY;
         end else if (evt.eret) begin
            sync_src <= esvs_pkg::ESVS_SRC_RETURN;
         end else if (evt.dcps || evt.debug_restore_state) begin
            sync_src <= esvs_pkg::ESVS_SRC_DEBUG;
         end else begin
            sync_src <= esvs_pkg::ESVS_SRC_BARRIER;
         end
      end
   end

   // Barrier side effects on the physical path and own source
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         phys_sync <= 1'b0;
         idef_clear <= 1'b0;
         barrier_done <= 1'b0;
      end else if (ce) begin
         // physical sync runs with every barrier at level 0 or 1
         phys_sync <= barrier;
         idef_clear <= idef_go && core.virt_masked;
         barrier_done <= barrier && !phys_take_cur
                         && !((inj_sync || idef_go)
                              && !core.virt_masked);
      end
   end

   // ------------------------------------------------------------
   // Illegal return handling
   // ------------------------------------------------------------
   // flag on illegal return, exception on next instruction
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         illegal_q <= 1'b0;
         illegal_state_exc <= 1'b0;
      end else if (ce) begin
         illegal_state_exc <= 1'b0;
         if (evt.eret && evt.illegal) begin
            illegal_q <= 1'b1;
         end else if (illegal_q && evt.next_instr) begin
            illegal_q <= 1'b0;
            illegal_state_exc <= 1'b1;
         end
      end
   end

   assign illegal_state_flag = illegal_q;
   assign virt_error_inject = inject_q;

   // ------------------------------------------------------------
   // Register read port
   // ------------------------------------------------------------
   // Data valid only in the cycle after the read strobe
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         reg_rdata <= `ESVS_ZERO32;
      end else if (ce) begin
         reg_rdata <= `ESVS_ZERO32;
         if (reg_rd) begin
            unique case (reg_addr)
               `ESVS_OFF_HCTL: begin
                  reg_rdata[`ESVS_HCTL_EN] <= el2_en_q;
                  reg_rdata[`ESVS_HCTL_ROUTE] <= hyp_async_abort_route_q;
                  reg_rdata[`ESVS_HCTL_TGE] <= hyp_trap_general_q;
                  reg_rdata[`ESVS_HCTL_INJ] <= inject_q;
               end
               `ESVS_OFF_VSYN: begin
                  reg_rdata[SYN_W-1:0] <= virt_syndrome_reg_q;
               end
               `ESVS_OFF_VREC: begin
                  reg_rdata[`ESVS_VREC_PEND] <= rec_pend_q;
                  reg_rdata[SYN_W-1:0] <= rec_syn_q;
               end
               `ESVS_OFF_SCTL: begin
                  reg_rdata[`ESVS_SCTL_ISE_HI:`ESVS_SCTL_ISE_LO] <=
                     implicit_sync_enable_q[3:1];
                  reg_rdata[`ESVS_SCTL_NMEA] <=
                     nonmaskable_abort_enable_q;
               end
               `ESVS_OFF_STAT: begin
                  reg_rdata[`ESVS_SCTL_ISE_HI:`ESVS_SCTL_ISE_LO] <=
                     ise_eff[3:1];
                  reg_rdata[`ESVS_STAT_ILL] <= illegal_q;
                  reg_rdata[`ESVS_STAT_VPEND] <= inject_q;
               end
               default: reg_rdata <= `ESVS_ZERO32;
            endcase
         end
      end
   end

endmodule : esvs_unit

// >>> tb/esvs_unit_chk.sv
// Port assertions of the error sync unit
`timescale 1ns/1ps
module esvs_unit_chk (
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic ce,
   input wire logic reg_wr,
   input wire esvs_pkg::esvs_evt_t evt,
   input wire esvs_pkg::esvs_core_t core,
   input wire esvs_pkg::esvs_take_t take,
   input wire logic sync_event,
   input wire logic phys_sync,
   input wire logic idef_clear,
   input wire logic barrier_done,
   input wire logic illegal_state_flag,
   input wire logic illegal_state_exc,
   input wire logic virt_error_inject
);
   // ------------------------------------------------------------
   // Clocking and helpers
   // ------------------------------------------------------------
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (!rst_n);
   // Barrier, entry, return, switch and restore strobes
   logic [4:0] stb;
   assign stb = {evt.error_sync_barrier_instr, evt.entry, evt.eret, evt.dcps, evt.debug_restore_state};

   // ------------------------------------------------------------
   // Properties
   // ------------------------------------------------------------
   property p_bar_phys;
      ce && evt.error_sync_barrier_instr && !core.cur_el[1] |=> phys_sync;
   endproperty
   a_bar_phys: assert property (p_bar_phys)
      else $error("no physical sync");
   property p_bar_high;
      ce && stb == 5'h10 && core.cur_el[1] |=>
         !phys_sync && !barrier_done && !take.take_virt && !idef_clear;
   endproperty
   a_bar_high: assert property (p_bar_high)
      else $error("high level barrier acted");
   property p_inj_hold;
      ce && !reg_wr && !evt.error_sync_barrier_instr |=> $stable(virt_error_inject);
   endproperty
   a_inj_hold: assert property (p_inj_hold)
      else $error("inject bit changed");
   property p_flag_vec;
      take.iesb_flag |->
         take.take_phys && take.ret_sel != esvs_pkg::ESVS_RET_INSTR;
   endproperty
   a_flag_vec: assert property (p_flag_vec)
      else $error("bad flagged take");
   property p_virt_done;
      $past(ce) && take.take_virt |-> !barrier_done && $past(evt.error_sync_barrier_instr);
   endproperty
   a_virt_done: assert property (p_virt_done)
      else $error("bad virtual take");
   property p_entry_off;
      ce && stb == 5'h08 && (evt.el == 2'h0 || !core.a64[evt.el])
         |=> !sync_event && !take.take_phys;
   endproperty
   a_entry_off: assert property (p_entry_off)
      else $error("disabled entry acted");
   property p_ill_exc;
      $past(ce) && illegal_state_exc |-> $past(illegal_state_flag)
         && $past(evt.next_instr) && !illegal_state_flag;
   endproperty
   a_ill_exc: assert property (p_ill_exc)
      else $error("bad illegal state trap");
   property p_idef;
      $past(ce) && idef_clear |-> $past(evt.error_sync_barrier_instr)
         && $past(core.idef_pend) && !$past(core.cur_el[1]);
   endproperty
   a_idef: assert property (p_idef)
      else $error("bad own source clear");
endmodule : esvs_unit_chk

bind esvs_unit esvs_unit_chk u_esvs_unit_chk (
   .mclk(mclk), .rst_n(rst_n), .ce(ce), .reg_wr(reg_wr), .evt(evt),
   .core(core), .take(take), .sync_event(sync_event),
   .phys_sync(phys_sync), .idef_clear(idef_clear),
   .barrier_done(barrier_done), .illegal_state_flag(illegal_state_flag),
   .illegal_state_exc(illegal_state_exc),
   .virt_error_inject(virt_error_inject)
);

// >>> tb/esvs_unit_test.sv
// Self-checking bench for the error sync unit
`timescale 1ns/1ps
`include "esvs_defines.svh"
module esvs_unit_test;
   // ------------------------------------------------------------
   // Signals
   // ------------------------------------------------------------
   localparam logic [24:0] IDS = 25'h1ab_cdef;
   localparam logic [9:0] B_TP = 10'h200, B_TV = 10'h100, B_FL = 10'h080;
   localparam logic [9:0] B_RET = 10'h040, B_VEC = 10'h020, B_SE = 10'h010;
   localparam logic [9:0] B_PS = 10'h008, B_IC = 10'h004, B_BD = 10'h002;
   localparam logic [9:0] B_IE = 10'h001;
   logic mclk = 1'b0;
   logic rst_n = 1'b0;
   logic ce = 1'b1;
   logic [`ESVS_ADDR_W-1:0] reg_addr = 5'h00;
   logic [31:0] reg_wdata = 32'h0;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic [31:0] reg_rdata;
   esvs_pkg::esvs_evt_t evt = '0;
   esvs_pkg::esvs_core_t core = '0;
   esvs_pkg::esvs_core_t c = '0;
   esvs_pkg::esvs_take_t take;
   esvs_pkg::esvs_src_t sync_src;
   logic sync_event, phys_sync, idef_clear, barrier_done;
   logic illegal_state_flag, illegal_state_exc, virt_error_inject;
   logic [31:0] rq[$];
   logic [11:0] eq[$];
   logic [31:0] hv[3] = '{32'h9, 32'ha, 32'hf};
   logic rd_d = 1'b0;
   logic ev_d = 1'b0;
   logic [31:0] seed = 32'he224;
   logic [31:0] syn;
   int n_fail = 0;
   int compares = 0;
   int cyc = 0;

   esvs_unit #(.IDEF_SYN(IDS), .ERET_FLAG(1'b0)) u_esvs_unit (
      .mclk(mclk), .rst_n(rst_n), .ce(ce), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_rdata(reg_rdata), .evt(evt), .core(core), .take(take),
      .sync_event(sync_event), .sync_src(sync_src),
      .phys_sync(phys_sync), .idef_clear(idef_clear),
      .barrier_done(barrier_done), .illegal_state_flag(illegal_state_flag),
      .illegal_state_exc(illegal_state_exc),
      .virt_error_inject(virt_error_inject)
   );

   // ------------------------------------------------------------
   // Clock, timeout and result watcher
   // ------------------------------------------------------------
   always #5 mclk = ~mclk;
   // Marks which cycles carry a read or an event answer
   always @(posedge mclk) begin
      cyc <= cyc + 1;
      rd_d <= reg_rd && rst_n;
      ev_d <= (|{evt.error_sync_barrier_instr, evt.entry, evt.eret, evt.dcps, evt.debug_restore_state,
                 evt.next_instr}) && rst_n;
      if (cyc == 2000) begin
         n_fail++;
         final_report();
      end
   end
   // Compares each answer with the oldest note
   always @(negedge mclk) begin
      if (rd_d) chk_rd();
      if (ev_d) chk_ev();
   end

   // ------------------------------------------------------------
   // Tasks
   // ------------------------------------------------------------
   function automatic logic [31:0] xs(input logic [31:0] s);
      logic [31:0] v;
      v = s ^ (s << 13);
      v = v ^ (v >> 17);
      return v ^ (v << 5);
   endfunction : xs
   task automatic chk_rd();
      logic [31:0] x;
      x = rq.pop_front();
      compares++;
      if (reg_rdata !== x) begin
         n_fail++;
         $display("CHECK FAILED reg_rdata exp %h got %h", x, reg_rdata);
      end
   endtask : chk_rd
   task automatic chk_ev();
      logic [11:0] x;
      logic [11:0] o;
      x = eq.pop_front();
      o = {sync_src, take.take_phys, take.take_virt, take.iesb_flag,
           take.ret_sel,
           sync_event, phys_sync, idef_clear, barrier_done,
           illegal_state_exc};
      compares++;
      if (o !== x) begin
         n_fail++;
         $display("CHECK FAILED event outputs exp %h got %h", x, o);
      end
   endtask : chk_ev
   // One cycle of every input, changed just after the edge
   task automatic put(input logic w, input logic r, input logic [4:0] a,
                      input logic [31:0] d, input esvs_pkg::esvs_evt_t e);
      @(posedge mclk);
      reg_wr <= w;
      reg_rd <= r;
      reg_addr <= a;
      reg_wdata <= d;
      evt <= e;
      core <= c;
   endtask : put
   task automatic wr(input logic [4:0] a, input logic [31:0] d);
      put(1'b1, 1'b0, a, d, '0);
   endtask : wr
   task automatic rd(input logic [4:0] a, input logic [31:0] x);
      put(1'b0, 1'b1, a, 32'h0, '0);
      rq.push_back(x);
   endtask : rd
   // Kind 0 barrier, 1 entry, 2 return, 3 switch, 4 restore, 5 next
   task automatic ev(input logic [2:0] k, input logic [1:0] el,
                     input logic [1:0] q, input logic [9:0] x);
      esvs_pkg::esvs_evt_t e;
      esvs_pkg::esvs_src_t s;
      e = (k > 3'h4) ? 10'h001 : 10'h200 >> k;
      e.el = el;
      e.illegal = q[1];
      e.raises_exc = q[0];
      case (k)
         3'h1: s = esvs_pkg::ESVS_SRC_ENTRY;
         3'h2: s = esvs_pkg::ESVS_SRC_RETURN;
         3'h3, 3'h4: s = esvs_pkg::ESVS_SRC_DEBUG;
         default: s = esvs_pkg::ESVS_SRC_BARRIER;
      endcase
      put(1'b0, 1'b0, 5'h00, 32'h0, e);
      eq.push_back({s, x});
   endtask : ev
   task automatic final_report();
      if (n_fail == 0 && compares > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask : final_report

   // ------------------------------------------------------------
   // Scenarios
   // ------------------------------------------------------------
   initial begin
      repeat (3) @(posedge mclk);
      rst_n <= 1'b1;
      // Reset values, then an unmapped word
      for (int i = 0; i < 6; i++) rd(5'(i * 4), 32'h0);
      wr(5'h14, 32'hffff_ffff);
      rd(5'h14, 32'h0);
      // Masked injected error, random syndrome
      seed = xs(seed);
      syn = seed & 32'h01ff_ffff;
      wr(`ESVS_OFF_VSYN, syn);
      wr(`ESVS_OFF_HCTL, 32'hb);
      rd(`ESVS_OFF_STAT, 32'h20);
      c.cur_el = 2'h1;
      c.virt_masked = 1'b1;
      ev(3'h0, 2'h0, 2'h0, B_SE | B_PS | B_BD);
      rd(`ESVS_OFF_VREC, 32'h8000_0000 | syn);
      rd(`ESVS_OFF_STAT, 32'h0);
      // Unmasked injected error at level 0
      wr(`ESVS_OFF_VREC, 32'h0);
      wr(`ESVS_OFF_HCTL, 32'hb);
      c.cur_el = 2'h0;
      c.virt_masked = 1'b0;
      ev(3'h0, 2'h0, 2'h0, B_TV | B_SE | B_PS);
      rd(`ESVS_OFF_VREC, 32'h0);
      // Missing route, missing enable or trap set leaves it pending
      c.cur_el = 2'h1;
      c.virt_masked = 1'b1;
      foreach (hv[i]) begin
         wr(`ESVS_OFF_HCTL, hv[i]);
         ev(3'h0, 2'h0, 2'h0, B_SE | B_PS | B_BD);
         rd(`ESVS_OFF_VREC, 32'h0);
         rd(`ESVS_OFF_STAT, 32'h20);
      end
      // Level 2 barrier ignored
      wr(`ESVS_OFF_HCTL, 32'hb);
      c.cur_el = 2'h2;
      ev(3'h0, 2'h0, 2'h0, 10'h0);
      rd(`ESVS_OFF_STAT, 32'h20);
      // Own-source error
      wr(`ESVS_OFF_HCTL, 32'h3);
      c.cur_el = 2'h1;
      c.idef_pend = 1'b1;
      c.idef_sync = 1'b1;
      ev(3'h0, 2'h0, 2'h0, B_SE | B_PS | B_BD | B_IC);
      rd(`ESVS_OFF_VREC, 32'h8000_0000 | 32'(IDS));
      wr(`ESVS_OFF_VREC, 32'h0);
      c.idef_sync = 1'b0;
      ev(3'h0, 2'h0, 2'h0, B_SE | B_PS | B_BD);
      rd(`ESVS_OFF_VREC, 32'h0);
      // Entry events
      c = '0;
      wr(`ESVS_OFF_SCTL, 32'he);
      rd(`ESVS_OFF_STAT, 32'he);
      c.a64 = 4'he;
      c.phys_pend = 1'b1;
      for (int l = 1; l < 4; l++)
         ev(3'h1, 2'(l), 2'h0, B_TP | B_FL | B_VEC | B_SE);
      c.phys_masked = 4'he;
      ev(3'h1, 2'h2, 2'h0, B_SE);
      c.a64 = 4'h0;
      ev(3'h1, 2'h1, 2'h0, 10'h0);
      rd(`ESVS_OFF_VREC, 32'h0);
      // Forced level 3 enable
      c = '0;
      c.a64 = 4'h8;
      wr(`ESVS_OFF_SCTL, 32'h10);
      rd(`ESVS_OFF_STAT, 32'h08);
      ev(3'h1, 2'h3, 2'h0, B_SE);
      wr(`ESVS_OFF_SCTL, 32'h0);
      ev(3'h1, 2'h3, 2'h0, 10'h0);
      // Debug switch
      wr(`ESVS_OFF_SCTL, 32'h4);
      c.a64 = 4'h4;
      c.debug = 1'b1;
      ev(3'h3, 2'h2, 2'h0, B_SE);
      c.debug = 1'b0;
      ev(3'h3, 2'h2, 2'h0, 10'h0);
      // Returns and restores at level 1
      wr(`ESVS_OFF_SCTL, 32'h2);
      c.a64 = 4'h2;
      c.cur_el = 2'h1;
      ev(3'h2, 2'h0, 2'h0, B_SE);
      ev(3'h2, 2'h0, 2'h1, 10'h0);
      c.phys_pend = 1'b1;
      ev(3'h2, 2'h0, 2'h0, B_TP | B_RET | B_SE);
      c.phys_pend = 1'b0;
      c.debug = 1'b1;
      ev(3'h4, 2'h0, 2'h0, B_SE);
      ev(3'h4, 2'h0, 2'h1, 10'h0);
      c.debug = 1'b0;
      ev(3'h4, 2'h0, 2'h0, 10'h0);
      // Illegal return, then next instruction
      ev(3'h2, 2'h0, 2'h2, B_SE);
      rd(`ESVS_OFF_STAT, 32'h12);
      ev(3'h5, 2'h0, 2'h0, B_IE);
      rd(`ESVS_OFF_STAT, 32'h02);
      c.cur_el = 2'h0;
      ev(3'h2, 2'h0, 2'h0, 10'h0);
      put(1'b0, 1'b0, 5'h00, 32'h0, '0);
      repeat (3) @(posedge mclk);
      final_report();
   end
endmodule : esvs_unit_test
